// file: src/cause_if.sv
/*
 * Carrier between the register front end and the cause latch.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ns
interface cause_if;
    logic [14:0] raw_event;   // one-cycle event pulses, bit per cause
    logic an_enable;          // autonegotiation enabled
    logic advert_all;         // advertisement bits 8:5 all set
    logic carrier_ext;        // rx error used for carrier extension
    logic clear_on_read;      // status register read this cycle
    logic soft_reset;
    logic [15:0] status;      // summary in 15, causes in 14:0

    modport latch (
        input raw_event,
        input an_enable,
        input advert_all,
        input carrier_ext,
        input clear_on_read,
        input soft_reset,
        output status
    );
    modport ctrl (
        output raw_event,
        output an_enable,
        output advert_all,
        output carrier_ext,
        output clear_on_read,
        output soft_reset,
        input status
    );
endinterface : cause_if

// file: src/cause_latch.sv
/*
 * Sticky latch of the interrupt causes with clear-on-read and summary.
 * Assumes event pulses are on the core clock; read clear is one cycle.
 */
`timescale 1ns/1ns
module cause_latch (
    input wire logic clk,
    input wire logic reset_n,
    cause_if.latch cif
);
    logic [14:0] pend_r;
    logic [14:0] pend_nxt;
    logic [14:0] gated;

    // qualify events, then clear on read with set winning
    always_comb begin
        gated = cif.raw_event;
        if (!cif.an_enable) begin
            gated[phy_irq_pkg::SPEED_CHG_BIT] = 1'b0;
            gated[phy_irq_pkg::DUPLEX_CHG_BIT] = 1'b0;
        end
        if (!cif.advert_all) begin
            gated[phy_irq_pkg::DOWNSHIFT_BIT] = 1'b0;
        end
        if (cif.carrier_ext) begin
            gated[phy_irq_pkg::RX_ERROR_BIT] = 1'b0;
        end
        gated[phy_irq_pkg::CAUSE_RSVD_BIT] = 1'b0;
        pend_nxt = pend_r;
        if (cif.clear_on_read || cif.soft_reset) begin
            pend_nxt = '0;
        end
        // latching does not depend on any mask or pin enable
        pend_nxt = pend_nxt | gated;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pend_r <= phy_irq_pkg::CAUSE_STATUS_RESET[14:0];
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // summary flag follows any pending cause
    assign cif.status = {|pend_r, pend_r};

endmodule : cause_latch

// file: src/phy_interrupt_aux_status.sv
/*
 * Interrupt cause status register and auxiliary control/status register
 * of one PHY port, with the management interrupt pin.
 * Assumes all inputs come from logic on the core clock, so none is
 * synchronised; registers are reached by number over a plain port.
 */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
// What this block does
// - reading the cause status register clears every set cause bit, except one with a new event in the read cycle
// - bit 15 summarises pending causes; causes readable in bits 14:0
// - speed and duplex change causes only latch with autonegotiation on
// - downshift cause only latches when advertisement bits 8:5 all set
// - rx error cause suppressed while rx error marks carrier extension
// - upper causes: speed, link, duplex, an error, an complete
// - lower causes in bits 9:0; bit 6 reserved and reads zero
// - causes latch regardless of interrupt pin use; host may poll
// - aux bit 15: an complete when an enabled, else link status
// - aux bit 14: an disabled, or media sensing with 100 fiber mode
// - aux bit 13 shows an internal crossover was performed
// - aux bit 12 shows C and D pairs swapped
// - aux bits 11:8 show polarity inversion on pairs A to D
// - sticky two-bit power-save time-out in bits 7 and 2, reset 01
// - aux bit 5 duplex, bits 4:3 speed code
// - aux bits 1:0 report active media
// - interrupt pin follows summary bit while pin enable is set
module phy_interrupt_aux_status (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic soft_reset,
    input wire logic an_enable,
    input wire logic an_complete,
    input wire logic link_up,
    input wire logic [3:0] advert_8_5,
    input wire logic carrier_ext,
    input wire logic irq_pin_enable,
    input wire logic auto_media_sense,
    input wire logic fx_100_mode,
    input wire logic auto_crossover,
    input wire logic cd_pair_swap,
    input wire logic [3:0] pair_polarity,
    input wire logic duplex_state,
    input wire logic [1:0] speed_state,
    input wire logic [1:0] media_state,
    input wire logic [14:0] cause_event,
    output logic mgmt_interrupt_pin,
    output logic power_save_link_enable,
    output logic [1:0] power_save_link_timeout
);
    cause_if cif ();

    logic status_rd;
    logic aux_rd;
    logic aux_wr;
    logic [15:0] aux_value;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic pin_r;
    logic pin_nxt;
    logic [1:0] timeout_r;
    logic [1:0] timeout_nxt;
    logic ps_enable_r;
    logic ps_enable_nxt;

    cause_latch u_cause_latch (
        .clk(clk),
        .reset_n(reset_n),
        .cif(cif.latch)
    );

    // address decode
    always_comb begin
        status_rd = 1'b0;
        aux_rd = 1'b0;
        aux_wr = 1'b0;
        if (reg_addr == phy_irq_pkg::CAUSE_STATUS_ADDR) begin
            status_rd = reg_rd;
        end else if (reg_addr == phy_irq_pkg::AUX_CTRL_STATUS_ADDR) begin
            aux_rd = reg_rd;
            aux_wr = reg_wr;
        end
    end

    // cause latch inputs; the status register has no writable bits
    assign cif.raw_event = cause_event;
    assign cif.an_enable = an_enable;
    assign cif.advert_all = &advert_8_5;
    assign cif.carrier_ext = carrier_ext;
    assign cif.clear_on_read = status_rd;
    assign cif.soft_reset = soft_reset;

    // auxiliary register image: live status plus sticky settings
    always_comb begin
        aux_value = 16'h0000;
        aux_value[phy_irq_pkg::AUX_AN_DONE_BIT] =
            an_enable ? an_complete : link_up;
        aux_value[phy_irq_pkg::AUX_AN_OFF_BIT] =
            !an_enable || (auto_media_sense && fx_100_mode);
        aux_value[phy_irq_pkg::AUX_CROSSOVER_BIT] = auto_crossover;
        aux_value[phy_irq_pkg::AUX_CD_SWAP_BIT] = cd_pair_swap;
        aux_value[phy_irq_pkg::AUX_POL_LSB +: 4] =
            {pair_polarity[0], pair_polarity[1],
             pair_polarity[2], pair_polarity[3]};
        aux_value[phy_irq_pkg::AUX_TIMEOUT_HI_BIT] = timeout_r[1];
        aux_value[phy_irq_pkg::AUX_PS_ENABLE_BIT] = ps_enable_r;
        aux_value[phy_irq_pkg::AUX_DUPLEX_BIT] = duplex_state;
        aux_value[phy_irq_pkg::AUX_SPEED_LSB +: 2] = speed_state;
        aux_value[phy_irq_pkg::AUX_TIMEOUT_LO_BIT] = timeout_r[0];
        aux_value[phy_irq_pkg::AUX_MEDIA_LSB +: 2] = media_state;
    end

    // read data: captured at the strobe, shown only the cycle after
    always_comb begin
        rdata_nxt = 16'h0000;  // unmapped numbers read as zero
        if (status_rd) begin
            rdata_nxt = cif.status;
        end else if (aux_rd) begin
            rdata_nxt = aux_value;
        end
    end

    // sticky settings: only the hard reset restores them
    always_comb begin
        timeout_nxt = timeout_r;
        ps_enable_nxt = ps_enable_r;
        if (aux_wr) begin
            timeout_nxt = {reg_wdata[phy_irq_pkg::AUX_TIMEOUT_HI_BIT],
                           reg_wdata[phy_irq_pkg::AUX_TIMEOUT_LO_BIT]};
            ps_enable_nxt = reg_wdata[phy_irq_pkg::AUX_PS_ENABLE_BIT];
        end
    end

    // pin gate; clearing the enable only blocks the pin, not the latch
    always_comb begin
        pin_nxt = irq_pin_enable && cif.status[phy_irq_pkg::SUMMARY_BIT];
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_r <= phy_irq_pkg::RDATA_RESET;
            pin_r <= 1'b0;
            timeout_r <= phy_irq_pkg::TIMEOUT_RESET;
            ps_enable_r <= phy_irq_pkg::PS_ENABLE_RESET;
        end else begin
            rdata_r <= rdata_nxt;
            pin_r <= pin_nxt;
            timeout_r <= timeout_nxt;
            ps_enable_r <= ps_enable_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign mgmt_interrupt_pin = pin_r;
    assign power_save_link_enable = ps_enable_r;
    assign power_save_link_timeout = timeout_r;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_status_read;
        reg_rd && reg_addr == phy_irq_pkg::CAUSE_STATUS_ADDR;
    endsequence

    sequence s_quiet_read;
        s_status_read ##0 (cause_event == 15'h0000);
    endsequence

    sequence s_aux_read;
        reg_rd && reg_addr == phy_irq_pkg::AUX_CTRL_STATUS_ADDR;
    endsequence

    // a quiet read leaves nothing pending and drops the pin
    property p_clear_on_read;
        s_quiet_read |=> (cif.status == 16'h0000) ##1 !mgmt_interrupt_pin;
    endproperty
    a_clear_on_read: assert property (p_clear_on_read)
        else $error("status not cleared by read");

    property p_summary;
        (cause_event[phy_irq_pkg::LINK_CHG_BIT] && !soft_reset) |=>
            cif.status[phy_irq_pkg::SUMMARY_BIT];
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary not set by pending cause");

    property p_speed_gate;
        (!an_enable && !cif.status[phy_irq_pkg::SPEED_CHG_BIT]) |=>
            !cif.status[phy_irq_pkg::SPEED_CHG_BIT];
    endproperty
    a_speed_gate: assert property (p_speed_gate)
        else $error("speed change latched with autoneg off");

    property p_downshift_gate;
        (advert_8_5 != 4'hf && !cif.status[phy_irq_pkg::DOWNSHIFT_BIT]) |=>
            !cif.status[phy_irq_pkg::DOWNSHIFT_BIT];
    endproperty
    a_downshift_gate: assert property (p_downshift_gate)
        else $error("downshift latched without full advert");

    property p_rx_error_gate;
        (carrier_ext && !cif.status[phy_irq_pkg::RX_ERROR_BIT]) |=>
            !cif.status[phy_irq_pkg::RX_ERROR_BIT];
    endproperty
    a_rx_error_gate: assert property (p_rx_error_gate)
        else $error("rx error latched during carrier extension");

    property p_event_survives_read;
        (s_status_read ##0 (cause_event[phy_irq_pkg::AN_DONE_BIT] &&
            !soft_reset)) |=> cif.status[phy_irq_pkg::AN_DONE_BIT];
    endproperty
    a_event_survives_read: assert property (p_event_survives_read)
        else $error("event lost in read cycle");

    property p_reserved_zero;
        s_status_read |=> reg_rdata[phy_irq_pkg::CAUSE_RSVD_BIT] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved cause bit reads one");

    property p_aux_an_done;
        (reg_rd && reg_addr == phy_irq_pkg::AUX_CTRL_STATUS_ADDR) |=>
            reg_rdata[phy_irq_pkg::AUX_AN_DONE_BIT] ==
            ($past(an_enable) ? $past(an_complete) : $past(link_up));
    endproperty
    a_aux_an_done: assert property (p_aux_an_done)
        else $error("aux an complete bit wrong");

    property p_aux_an_off;
        (reg_rd && reg_addr == phy_irq_pkg::AUX_CTRL_STATUS_ADDR) |=>
            reg_rdata[phy_irq_pkg::AUX_AN_OFF_BIT] == (!$past(an_enable) ||
            ($past(auto_media_sense) && $past(fx_100_mode)));
    endproperty
    a_aux_an_off: assert property (p_aux_an_off)
        else $error("aux an disabled bit wrong");

    property p_duplex_gate;
        (!an_enable && !cif.status[phy_irq_pkg::DUPLEX_CHG_BIT]) |=>
            !cif.status[phy_irq_pkg::DUPLEX_CHG_BIT];
    endproperty
    a_duplex_gate: assert property (p_duplex_gate)
        else $error("duplex change latched with autoneg off");

    // live levels are taken with the strobe, so compare against the past
    property p_aux_crossover;
        s_aux_read |=> reg_rdata[phy_irq_pkg::AUX_CROSSOVER_BIT] ==
            $past(auto_crossover);
    endproperty
    a_aux_crossover: assert property (p_aux_crossover)
        else $error("aux crossover bit wrong");

    property p_aux_cd_swap;
        s_aux_read |=> reg_rdata[phy_irq_pkg::AUX_CD_SWAP_BIT] ==
            $past(cd_pair_swap);
    endproperty
    a_aux_cd_swap: assert property (p_aux_cd_swap)
        else $error("aux pair swap bit wrong");

    // pair A sits in the highest polarity bit, pair D in the lowest
    property p_aux_polarity;
        s_aux_read |=> reg_rdata[phy_irq_pkg::AUX_POL_LSB +: 4] ==
            {$past(pair_polarity[0]), $past(pair_polarity[1]),
            $past(pair_polarity[2]), $past(pair_polarity[3])};
    endproperty
    a_aux_polarity: assert property (p_aux_polarity)
        else $error("aux polarity bits wrong");

    property p_aux_speed_duplex;
        s_aux_read |=> reg_rdata[phy_irq_pkg::AUX_SPEED_LSB +: 2] ==
            $past(speed_state) &&
            reg_rdata[phy_irq_pkg::AUX_DUPLEX_BIT] == $past(duplex_state);
    endproperty
    a_aux_speed_duplex: assert property (p_aux_speed_duplex)
        else $error("aux speed or duplex wrong");

    property p_aux_media;
        s_aux_read |=> reg_rdata[phy_irq_pkg::AUX_MEDIA_LSB +: 2] ==
            $past(media_state);
    endproperty
    a_aux_media: assert property (p_aux_media)
        else $error("aux media bits wrong");

    property p_timeout_write;
        (reg_wr && reg_addr == phy_irq_pkg::AUX_CTRL_STATUS_ADDR) |=>
            power_save_link_timeout ==
            {$past(reg_wdata[phy_irq_pkg::AUX_TIMEOUT_HI_BIT]),
            $past(reg_wdata[phy_irq_pkg::AUX_TIMEOUT_LO_BIT])};
    endproperty
    a_timeout_write: assert property (p_timeout_write)
        else $error("time-out field not taken from write");

    property p_sticky_settings;
        (soft_reset && !reg_wr) |=>
            $stable(power_save_link_timeout) && $stable(power_save_link_enable);
    endproperty
    a_sticky_settings: assert property (p_sticky_settings)
        else $error("sticky setting changed by soft reset");

    property p_pin_follows;
        (irq_pin_enable && cif.status[phy_irq_pkg::SUMMARY_BIT]) |=>
            mgmt_interrupt_pin;
    endproperty
    a_pin_follows: assert property (p_pin_follows)
        else $error("pin not asserted for pending cause");

    property p_pin_blocked;
        !irq_pin_enable |=> !mgmt_interrupt_pin;
    endproperty
    a_pin_blocked: assert property (p_pin_blocked)
        else $error("pin asserted while disabled");

endmodule : phy_interrupt_aux_status

// file: src/phy_irq_pkg.sv
/*
 * Constants for the interrupt cause status and auxiliary control/status
 * registers: register numbers, bit positions, field codes, reset values.
 * Assumes a 5-bit management register number and 16-bit register data.
 */
package phy_irq_pkg;

    // register numbers in the main management space
    localparam logic [4:0] CAUSE_STATUS_ADDR = 5'h1a;
    localparam logic [4:0] AUX_CTRL_STATUS_ADDR = 5'h1c;

    // interrupt cause status bit positions
    localparam int SUMMARY_BIT = 15;
    localparam int SPEED_CHG_BIT = 14;
    localparam int LINK_CHG_BIT = 13;
    localparam int DUPLEX_CHG_BIT = 12;
    localparam int AN_ERROR_BIT = 11;
    localparam int AN_DONE_BIT = 10;
    localparam int PD_DETECT_BIT = 9;
    localparam int SYMBOL_ERR_BIT = 8;
    localparam int FAST_LINK_FAIL_BIT = 7;
    localparam int CAUSE_RSVD_BIT = 6;
    localparam int EXTENDED_BIT = 5;
    localparam int MEDIA_CHG_BIT = 4;
    localparam int FALSE_CARRIER_BIT = 3;
    localparam int DOWNSHIFT_BIT = 2;
    localparam int MS_RES_ERR_BIT = 1;
    localparam int RX_ERROR_BIT = 0;
    localparam int CAUSE_COUNT = 15;

    // auxiliary control/status bit positions
    localparam int AUX_AN_DONE_BIT = 15;
    localparam int AUX_AN_OFF_BIT = 14;
    localparam int AUX_CROSSOVER_BIT = 13;
    localparam int AUX_CD_SWAP_BIT = 12;
    localparam int AUX_POL_LSB = 8;
    localparam int AUX_TIMEOUT_HI_BIT = 7;
    localparam int AUX_PS_ENABLE_BIT = 6;
    localparam int AUX_DUPLEX_BIT = 5;
    localparam int AUX_SPEED_LSB = 3;
    localparam int AUX_TIMEOUT_LO_BIT = 2;
    localparam int AUX_MEDIA_LSB = 0;

    // speed and media codes as reported in the auxiliary register
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    localparam logic [1:0] MEDIA_NONE = 2'h0;
    localparam logic [1:0] MEDIA_COPPER = 2'h1;
    localparam logic [1:0] MEDIA_SERIAL_FIBER = 2'h2;

    // reset values
    localparam logic [15:0] CAUSE_STATUS_RESET = 16'h0000;
    localparam logic [1:0] TIMEOUT_RESET = 2'h1;
    localparam logic PS_ENABLE_RESET = 1'b0;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

endpackage : phy_irq_pkg

// file: tb/mgmt_host.sv
/*
 * Station management host model: plain register port master with one
 * write task and one read task.
 * Assumes the slave answers a read in the cycle after the strobe.
 */
`timescale 1ns/1ns
module mgmt_host (
    input wire logic clk,
    output logic [4:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    // idle bus; address and data parked at zero
    initial begin
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write strobe beside address and data
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // polling read; data taken only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : mgmt_host

// file: tb/phy_interrupt_aux_status_tb.sv
/*
 * Self-checking bench: random cause events and status levels, compared
 * against a bench model of the latch and the auxiliary register.
 * Assumes a 100 MHz core clock and the host model in mgmt_host.
 */
`timescale 1ns/1ns
module phy_interrupt_aux_status_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, pin, ps_en;
    logic [1:0] ps_to;
    logic soft_reset = 1'b0, an_enable = 1'b0, an_complete = 1'b0;
    logic link_up = 1'b0, carrier_ext = 1'b0, irq_pin_enable = 1'b0;
    logic auto_media_sense = 1'b0, fx_100_mode = 1'b0, xover = 1'b0;
    logic cd_swap = 1'b0, duplex = 1'b0;
    logic [3:0] advert = 4'h0, pol = 4'h0;
    logic [1:0] speed = 2'h0, media = 2'h0;
    logic [14:0] cause_event = 15'h0000, pend = 15'h0000;
    logic [1:0] to_m = 2'h1; // model of the sticky time-out
    logic en_m = 1'b0;
    int miscompares = 0, checked = 0, cycles = 0;

    always #5 clk = ~clk;

    mgmt_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    phy_interrupt_aux_status uut (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .soft_reset(soft_reset),
        .an_enable(an_enable), .an_complete(an_complete),
        .link_up(link_up), .advert_8_5(advert), .carrier_ext(carrier_ext),
        .irq_pin_enable(irq_pin_enable),
        .auto_media_sense(auto_media_sense), .fx_100_mode(fx_100_mode),
        .auto_crossover(xover), .cd_pair_swap(cd_swap),
        .pair_polarity(pol), .duplex_state(duplex), .speed_state(speed),
        .media_state(media), .cause_event(cause_event),
        .mgmt_interrupt_pin(pin), .power_save_link_enable(ps_en),
        .power_save_link_timeout(ps_to));

    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // hang guard; a full run is well under two thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict;
        end
    end

    task automatic cmp_reg(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t read %h want %h", $time, g, e);
        end
    endtask : cmp_reg

    task automatic cmp_out(input logic [3:0] g, input logic [3:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t outputs %h want %h", $time, g, e);
        end
    endtask : cmp_out

    // which raw events the model lets latch under the current levels
    function automatic logic [14:0] gate(input logic [14:0] ev);
        logic [14:0] g;
        g = ev & 15'h7fbf;
        if (!an_enable) g = g & 15'h2fff;
        if (advert != 4'hf) g[2] = 1'b0;
        if (carrier_ext) g[0] = 1'b0;
        return g;
    endfunction : gate

    task automatic pulse(input logic [14:0] ev);
        @(posedge clk);
        cause_event <= ev;
        @(posedge clk);
        cause_event <= 15'h0000;
    endtask : pulse

    // status read with an event landing in the very read cycle
    task automatic rd_status(input logic [14:0] ev);
        logic [15:0] e;
        e = {|pend, pend};
        fork
            host.rd(phy_irq_pkg::CAUSE_STATUS_ADDR, d);
            pulse(ev);
        join
        cmp_reg(d, e);
        pend = gate(ev);
    endtask : rd_status

    task automatic check_pin;
        repeat (2) @(posedge clk);
        #1 cmp_out({3'h0, pin}, {3'h0, irq_pin_enable & |pend});
    endtask : check_pin

    task automatic rd_aux;
        logic [15:0] e;
        e = {an_enable ? an_complete : link_up,
            !an_enable | (auto_media_sense & fx_100_mode), xover, cd_swap,
            pol[0], pol[1], pol[2], pol[3], to_m[1], en_m, duplex, speed,
            to_m[0], media};
        host.rd(phy_irq_pkg::AUX_CTRL_STATUS_ADDR, d);
        cmp_reg(d, e);
    endtask : rd_aux

    task automatic wr_aux(input logic [15:0] w);
        host.wr(phy_irq_pkg::AUX_CTRL_STATUS_ADDR, w);
        to_m = {w[7], w[2]};
        en_m = w[6];
        #1 cmp_out({1'b0, ps_en, ps_to}, {1'b0, en_m, to_m});
    endtask : wr_aux

    initial begin
        void'($urandom(11262));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        #1 cmp_out({1'b0, ps_en, ps_to}, 4'h1);
        rd_status(15'h0000);
        // random levels and events; status polled and cleared
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            {an_enable, an_complete, link_up, carrier_ext} <= 4'($urandom);
            {irq_pin_enable, auto_media_sense, fx_100_mode} <= 3'($urandom);
            // crossover level is the settled one, after any renegotiation
            {xover, cd_swap, duplex, speed, media} <= 7'($urandom);
            pol <= 4'($urandom);
            advert <= ($urandom % 2) ? 4'hf : 4'($urandom);
            @(posedge clk);
            pulse(15'($urandom));
            check_pin;
            rd_aux;
            if (i % 3 == 0) wr_aux(16'($urandom));
            if (i % 2 == 0) begin
                rd_status(15'($urandom));
                check_pin;
            end
        end
        // status register is read-only; unmapped number reads zero
        host.wr(phy_irq_pkg::CAUSE_STATUS_ADDR, 16'hffff);
        rd_status(15'h0000);
        host.rd(5'h05, d);
        cmp_reg(d, 16'h0000);
        // soft reset drops causes, keeps the sticky fields
        wr_aux(16'h00c4);
        pulse(15'h7fff);
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        pend = 15'h0000;
        rd_status(15'h0000);
        #1 cmp_out({1'b0, ps_en, ps_to}, 4'h7);
        rd_aux;
        give_verdict;
    end

    // model update for the one-cycle pulses of the event bus
    always @(posedge clk) begin
        // status reads handle their own event in rd_status
        if (reset_n && cause_event !== 15'h0000 &&
            !(reg_rd && reg_addr == phy_irq_pkg::CAUSE_STATUS_ADDR))
            pend <= pend | gate(cause_event);
    end
endmodule : phy_interrupt_aux_status_tb
